// *** hw/system_reset_sequencer.sv ***
// System reset sequencer: drives and samples the open-drain reset pin,
// stretches resets, latches straps, resets modules and handles drive disable.
// Assumes pins reach it unsynchronised; one bus clock; no software registers.
//
// Rules for this block and the external strap logic
// R1 - Strap logic releases data lines before first bus cycle after reset.
// R2 - First bus cycle starts exactly ten bus clocks after the reset pin is sampled high.
// R3 - External logic should actively pull data lines low; pull-ups are weak.
// R4 - Other module pins default to ports with all directions input.
// R5 - External reset may wait for the current bus cycle to finish.
// R6 - During reset, integration-unit pins are floated or inactive.
// R7 - Latched external reset: drive pin low 512 more cycles after release.
// R8 - Internal request: drive pin at least 512 cycles, longer while active.
// R9 - After 512 cycles float pin ten cycles, then sample; high ends reset.
// R10 - Pin still low: drive 512 again, float ten, resample, repeat.
// R11 - At power-on hold reset until PLL lock plus 512 cycles.
// R12 - Modules reset after internal reset held four running clock cycles.
// R13 - Drive disable held ten clocks floats all outputs.
// R14 - With external clock, float after ten external clock pulses.
// R15 - Once floated, outputs stay floated until power cycle.
// R16 - Reset pin is synchronised by bus clock; async immediate, sync at cycle end.
// R17 - Straps latched during reset; high selects default function.
// R18 - Periods timed by bus clock counter; pin only pulled low or released.
`timescale 1ns/1ns

module system_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned STRETCH = STRETCH_CYCLES,
  parameter int unsigned FLOAT = FLOAT_CYCLES
) (
  // Clock and power-on reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Reset pin, open drain
  input wire logic RESET_PIN_N_I,
  output logic RESET_PIN_O,
  output logic RESET_PIN_OE_O,
  // Internal reset sources and status
  input wire logic PLL_LOCK_I,
  input wire logic INT_RESET_REQ_I,
  input wire logic BUS_CYCLE_END_I,
  input wire logic ASYNC_RESET_I,
  // Strap pins
  input wire logic [15:0] STRAP_DATA_I,
  input wire logic CLOCK_SOURCE_STRAP_I,
  input wire logic BREAKPOINT_PIN_N_I,
  // Drive disable
  input wire logic DRIVE_DISABLE_INPUT_I,
  input wire logic EXTERNAL_CLOCK_INPUT_I,
  // Outputs to the rest of the device
  output logic SYS_RESET_O,
  output logic MODULE_RESET_O,
  output logic FIRST_BUS_CYCLE_O,
  output logic PINS_ENABLE_O,
  output logic [7:0] PORT_DIR_O,
  output rst_seq_pkg::strap_s STRAP_O
);
  import rst_seq_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync_r, pin_sync_nxt;
  logic [1:0] dis_sync_r, dis_sync_nxt;
  logic [2:0] ext_sync_r, ext_sync_nxt;
  logic [1:0] lock_sync_r, lock_sync_nxt;
  logic [2*STRAP_DATA_W+3:0] strap_sync_r, strap_sync_nxt;
  logic pin_low;

  always_comb begin
    pin_sync_nxt = {pin_sync_r[0], RESET_PIN_N_I}; // R16
    dis_sync_nxt = {dis_sync_r[0], DRIVE_DISABLE_INPUT_I};
    ext_sync_nxt = {ext_sync_r[1:0], EXTERNAL_CLOCK_INPUT_I};
    lock_sync_nxt = {lock_sync_r[0], PLL_LOCK_I};
    strap_sync_nxt = {strap_sync_r[STRAP_DATA_W+1:0],
                      STRAP_DATA_I, CLOCK_SOURCE_STRAP_I, BREAKPOINT_PIN_N_I};
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pin_sync_r <= 2'b00;
      dis_sync_r <= 2'b00;
      ext_sync_r <= 3'b000;
      lock_sync_r <= 2'b00;
      strap_sync_r <= '1;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      dis_sync_r <= dis_sync_nxt;
      ext_sync_r <= ext_sync_nxt;
      lock_sync_r <= lock_sync_nxt;
      strap_sync_r <= strap_sync_nxt;
    end
  end

  assign pin_low = !pin_sync_r[1];

  // ----------------------------------------------------------------
  // Reset sequence
  // ----------------------------------------------------------------
  rst_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] mod_cnt_r, mod_cnt_nxt;
  logic ext_pending_r, ext_pending_nxt;
  strap_s strap_r, strap_nxt;

  // An external reset seen in mid bus cycle is latched and acted on when the cycle ends,
  // so a write in progress completes; a catastrophic one is taken at once.
  always_comb begin
    ext_pending_nxt = ext_pending_r;
    if (state_r != ST_RUN) begin
      ext_pending_nxt = 1'b0;
    end else if (pin_low && !ASYNC_RESET_I && !BUS_CYCLE_END_I) begin
      ext_pending_nxt = 1'b1; // R5
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    strap_nxt = strap_r;
    case (state_r)
      ST_POWER: begin
        if (lock_sync_r[1]) begin
          cnt_nxt = cnt_r + 1'b1; // R11
          if (cnt_r == CNT_W'(STRETCH - 1)) begin
            cnt_nxt = '0;
            state_nxt = ST_FLOAT;
          end
        end
      end
      ST_WAIT_EXT: begin
        // The pin is left to the outside driver; driving it here would hide its release.
        if (!pin_low) begin
          cnt_nxt = '0;
          state_nxt = ST_DRIVE; // R7
        end
      end
      ST_DRIVE: begin
        if (cnt_r != CNT_W'(STRETCH - 1)) begin
          cnt_nxt = cnt_r + 1'b1; // R18
        end else if (!INT_RESET_REQ_I) begin
          cnt_nxt = '0;
          state_nxt = ST_FLOAT; // R8
        end
      end
      ST_FLOAT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(FLOAT - 1)) begin
          cnt_nxt = '0;
          if (pin_low) begin
            state_nxt = ST_DRIVE; // R10
          end else begin
            state_nxt = ST_START; // R9
          end
        end
      end
      ST_START: begin
        // Straps are caught while reset is still in force.
        if (cnt_r == '0) begin
          strap_nxt.data = strap_sync_r[2*STRAP_DATA_W+3:STRAP_DATA_W+4]; // R17
          strap_nxt.clock_source = strap_sync_r[STRAP_DATA_W+3];
          strap_nxt.breakpoint = strap_sync_r[STRAP_DATA_W+2];
        end
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(FIRST_BUS_CYCLES - 1)) begin
          cnt_nxt = '0;
          state_nxt = ST_RUN; // R2
        end
      end
      ST_RUN: begin
        if (INT_RESET_REQ_I) begin
          cnt_nxt = '0;
          state_nxt = ST_DRIVE; // R8
        end else if ((pin_low || ext_pending_r) && (ASYNC_RESET_I || BUS_CYCLE_END_I)) begin
          state_nxt = ST_WAIT_EXT; // R16
        end
      end
      default: begin
        state_nxt = ST_POWER;
        cnt_nxt = '0;
      end
    endcase
  end

  always_comb begin
    mod_cnt_nxt = mod_cnt_r;
    if (state_r == ST_RUN || state_r == ST_START) begin
      mod_cnt_nxt = '0;
    end else if (mod_cnt_r != 3'(MODULE_RESET_CYCLES)) begin
      mod_cnt_nxt = mod_cnt_r + 1'b1; // R12
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_r <= ST_POWER;
      cnt_r <= '0;
      mod_cnt_r <= '0;
      ext_pending_r <= 1'b0;
      strap_r <= {STRAP_DATA_RST, STRAP_BIT_RST, STRAP_BIT_RST};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mod_cnt_r <= mod_cnt_nxt;
      ext_pending_r <= ext_pending_nxt;
      strap_r <= strap_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Drive disable
  // ----------------------------------------------------------------
  logic [3:0] dis_cnt_r, dis_cnt_nxt;
  logic floated_r, floated_nxt;
  logic ext_edge;

  assign ext_edge = ext_sync_r[1] && !ext_sync_r[2];

  always_comb begin
    dis_cnt_nxt = dis_cnt_r;
    floated_nxt = floated_r; // R15
    if (!dis_sync_r[1]) begin
      dis_cnt_nxt = '0;
    end else if (strap_r.clock_source || ext_edge) begin
      // With the external clock strapped only its rising edges count.
      if (dis_cnt_r == 4'(DRIVE_OFF_CYCLES - 1)) begin
        floated_nxt = 1'b1; // R13 R14
      end else begin
        dis_cnt_nxt = dis_cnt_r + 1'b1; // R13 R14
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      dis_cnt_r <= '0;
      floated_r <= 1'b0;
    end else begin
      dis_cnt_r <= dis_cnt_nxt;
      floated_r <= floated_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic in_reset_r, module_reset_r, first_r;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      in_reset_r <= 1'b1;
      module_reset_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      in_reset_r <= (state_nxt != ST_RUN);
      module_reset_r <= (mod_cnt_nxt == 3'(MODULE_RESET_CYCLES)); // R12
      first_r <= (state_r == ST_START) && (state_nxt == ST_RUN); // R2
    end
  end

  assign RESET_PIN_O = 1'b0; // R18
  assign RESET_PIN_OE_O = !floated_r &&
    (state_r == ST_POWER || state_r == ST_DRIVE);
  assign SYS_RESET_O = in_reset_r;
  assign MODULE_RESET_O = module_reset_r;
  assign FIRST_BUS_CYCLE_O = first_r;
  assign PINS_ENABLE_O = !in_reset_r && !floated_r; // R6
  assign PORT_DIR_O = PORT_DIR_RST; // R4
  assign STRAP_O = strap_r;

endmodule

// *** hw/rst_seq_pkg.sv ***
// Shared constants and carrier types for the system reset sequencer.
// Assumes a single 100 MHz bus clock domain; times are counted in its cycles.
package rst_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned STRETCH_CYCLES = 512;
  localparam int unsigned FLOAT_CYCLES = 10;
  localparam int unsigned FIRST_BUS_CYCLES = 10;
  localparam int unsigned MODULE_RESET_CYCLES = 4;
  localparam int unsigned DRIVE_OFF_CYCLES = 10;
  localparam int unsigned CNT_W = 10;

  // ----------------------------------------------------------------
  // Strap field positions and values after reset
  // ----------------------------------------------------------------
  localparam int unsigned STRAP_DATA_W = 16;
  localparam logic [15:0] STRAP_DATA_RST = 16'hffff;
  localparam logic STRAP_BIT_RST = 1'b1;
  localparam int unsigned PORT_W = 8;
  localparam logic [7:0] PORT_DIR_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_DRIVE = 3'b001,
    ST_FLOAT = 3'b010,
    ST_START = 3'b011,
    ST_RUN   = 3'b100,
    ST_WAIT_EXT = 3'b101
  } rst_state_e;

  typedef struct packed {
    logic [15:0] data;
    logic clock_source;
    logic breakpoint;
  } strap_s;

endpackage

// *** tb/rst_seq_props.sv ***
// Port checks for the reset sequencer, bound into every instance.
// Assumes the single bus clock and the synchronous active-high reset.
`timescale 1ns/1ns
module rst_seq_props
  import rst_seq_pkg::*;
#(
  parameter int unsigned STRETCH = 512,
  parameter int unsigned FLOAT = 10
) (
  // Clock, reset and request
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic DRIVE_DISABLE_INPUT_I,
  // Watched outputs
  input wire logic RESET_PIN_O,
  input wire logic RESET_PIN_OE_O,
  input wire logic SYS_RESET_O,
  input wire logic MODULE_RESET_O,
  input wire logic FIRST_BUS_CYCLE_O,
  input wire logic PINS_ENABLE_O,
  input wire logic [7:0] PORT_DIR_O,
  input wire rst_seq_pkg::strap_s STRAP_O
);
  int unsigned on_cnt;
  int unsigned off_cnt;
  int unsigned dd_cnt;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // Run lengths of pin drive, pin float and drive-disable request.
  always_ff @(posedge MCLK_I) begin
    on_cnt <= RESET_PIN_OE_O ? on_cnt + 1 : 0;
    off_cnt <= RESET_PIN_OE_O ? 0 : off_cnt + 1;
    dd_cnt <= DRIVE_DISABLE_INPUT_I ? dd_cnt + 1 : 0;
  end
  a_pin_open_drain: assert property (RESET_PIN_O == 1'b0)
    else $error("reset pin driven high");
  a_ports_input: assert property (PORT_DIR_O == 8'h00)
    else $error("port direction not input");
  a_first_single: assert property (FIRST_BUS_CYCLE_O |=> !FIRST_BUS_CYCLE_O)
    else $error("first bus cycle pulse too long");
  a_first_timing: assert property (FIRST_BUS_CYCLE_O |-> off_cnt >= FLOAT + 10 && off_cnt <= FLOAT + 14)
    else $error("first bus cycle off time");
  a_reset_quiet: assert property (SYS_RESET_O |-> !PINS_ENABLE_O && !FIRST_BUS_CYCLE_O)
    else $error("pins active in reset");
  a_stretch_min: assert property ($fell(RESET_PIN_OE_O) |-> on_cnt >= STRETCH)
    else $error("reset drive too short");
  a_float_min: assert property ($rose(RESET_PIN_OE_O) |-> off_cnt >= FLOAT)
    else $error("reset float too short");
  a_module_wait: assert property ($rose(MODULE_RESET_O) |-> $past(SYS_RESET_O, 4))
    else $error("module reset too early");
  a_strap_hold: assert property (!SYS_RESET_O && !$past(SYS_RESET_O) |-> $stable(STRAP_O))
    else $error("straps changed out of reset");
  a_drive_off: assert property (STRAP_O.clock_source && dd_cnt >= 14 |-> !PINS_ENABLE_O)
    else $error("drive disable ignored");
  a_float_sticky: assert property (!PINS_ENABLE_O && !SYS_RESET_O && !$past(SYS_RESET_O, 2) |=> !PINS_ENABLE_O)
    else $error("floated pins came back");
endmodule
bind system_reset_sequencer rst_seq_props #(.STRETCH(STRETCH), .FLOAT(FLOAT)) i_rst_seq_props (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .DRIVE_DISABLE_INPUT_I(DRIVE_DISABLE_INPUT_I),
  .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE_O(RESET_PIN_OE_O), .SYS_RESET_O(SYS_RESET_O),
  .MODULE_RESET_O(MODULE_RESET_O), .FIRST_BUS_CYCLE_O(FIRST_BUS_CYCLE_O), .PINS_ENABLE_O(PINS_ENABLE_O),
  .PORT_DIR_O(PORT_DIR_O), .STRAP_O(STRAP_O));

// *** tb/reset_source_model.sv ***
// External reset source and strap logic on the reset pin and data lines.
// Assumes a pull-up on the reset pin and weak pull-ups on the data lines.
`timescale 1ns/1ns
module reset_source_model #(
  parameter logic [15:0] STRAP_LEVELS = 16'h5aa5
) (
  input wire logic clk_i,
  input wire logic dev_pull_i,
  input wire logic ext_pull_i,
  output logic pin_n_o,
  output logic [15:0] data_o
);
  logic [2:0] hold_r = 3'h5;
  assign pin_n_o = !(dev_pull_i || ext_pull_i);
  always_ff @(posedge clk_i) begin
    hold_r <= !pin_n_o ? 3'h5 : (hold_r == 3'h0 ? 3'h0 : hold_r - 3'h1);
  end
  // Straps are pulled low actively and let go a few cycles after the pin rises.
  assign data_o = (hold_r != 3'h0) ? STRAP_LEVELS : 16'hffff;
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the reset sequencer.
// Assumes short stretch and float counts set through the parameters.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import rst_seq_pkg::*;
  localparam int STR = 8;
  localparam int FLT = 3;
  int errors = 0;
  int checks_done = 0;
  logic clk = 0, rst = 1, pll = 0, req = 0, bce = 1, asy = 0, cs = 1, dd = 0, xclk = 0, pull = 0;
  wire pin_n;
  wire [15:0] data;
  logic pin_o, oe, sysr, modr, first, pen;
  logic [7:0] pdir;
  strap_s strap;
  system_reset_sequencer #(.STRETCH(STR), .FLOAT(FLT)) i_system_reset_sequencer (
    .MCLK_I(clk), .RESET_I(rst), .RESET_PIN_N_I(pin_n), .RESET_PIN_O(pin_o), .RESET_PIN_OE_O(oe),
    .PLL_LOCK_I(pll), .INT_RESET_REQ_I(req), .BUS_CYCLE_END_I(bce), .ASYNC_RESET_I(asy),
    .STRAP_DATA_I(data), .CLOCK_SOURCE_STRAP_I(cs), .BREAKPOINT_PIN_N_I(1'b1),
    .DRIVE_DISABLE_INPUT_I(dd), .EXTERNAL_CLOCK_INPUT_I(xclk), .SYS_RESET_O(sysr), .MODULE_RESET_O(modr),
    .FIRST_BUS_CYCLE_O(first), .PINS_ENABLE_O(pen), .PORT_DIR_O(pdir), .STRAP_O(strap));
  reset_source_model i_reset_source_model (.clk_i(clk), .dev_pull_i(oe), .ext_pull_i(pull), .pin_n_o(pin_n),
    .data_o(data));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_run;
    for (int i = 0; i < 400 && first !== 1'b1; i++) tick(1);
    `CHK(first, 1'b1)
  endtask
  task automatic t_power;
    tick(20);
    `CHK(oe, 1'b1)
    pll = 1;
    tick(STR);
    `CHK(oe, 1'b1)
    wait_run;
    `CHK(strap, {16'h5aa5, 1'b1, 1'b1})
    `CHK(pdir, 8'h00)
    `CHK({sysr, modr, pen}, 3'b001)
  endtask
  task automatic t_ext(input logic now);
    bce = 0;
    asy = now;
    tick(2);
    pull = 1;
    tick(6);
    `CHK({sysr, oe}, {now, 1'b0})
    bce = 1;
    tick(4);
    `CHK({sysr, oe}, 2'b10)
    pull = 0;
    asy = 0;
    tick(STR);
    `CHK(oe, 1'b1)
    wait_run;
  endtask
  task automatic t_int;
    req = 1;
    tick(6);
    `CHK(modr, 1'b1)
    tick(3 * STR);
    `CHK(oe, 1'b1)
    req = 0;
    wait_run;
    `CHK(modr, 1'b0)
  endtask
  task automatic t_retry;
    int rises;
    logic prev;
    rises = 0;
    prev = oe;
    req = 1;
    pull = 1;
    for (int i = 0; i < 2 * (STR + FLT) + 6; i++) begin
      tick(1);
      req = 0;
      if (i == STR + FLT + 6) pull = 0;
      if (oe && !prev) rises++;
      prev = oe;
    end
    `CHK(rises, 2)
    wait_run;
  endtask
  task automatic t_drive_off(input logic src);
    rst = 1;
    cs = src;
    tick(12);
    rst = 0;
    wait_run;
    dd = 1;
    tick(9);
    `CHK(pen, 1'b1)
    if (!src) begin
      tick(20);
      `CHK(pen, 1'b1)
      for (int i = 0; i < 10; i++) begin
        xclk = 1;
        tick(2);
        xclk = 0;
        tick(2);
      end
    end
    tick(6);
    `CHK(pen, 1'b0)
    dd = 0;
    tick(10);
    `CHK(pen, 1'b0)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    complete_run;
  end
  initial begin
    tick(12);
    rst = 0;
    t_power;
    t_ext(1'b0);
    t_ext(1'b1);
    t_int;
    t_retry;
    t_drive_off(1'b0);
    t_drive_off(1'b1);
    complete_run;
  end
endmodule
